//--- shared/oepc_pkg.sv
// Constants, field layout and reset values of the pad configuration block
package oepc_pkg;
  // Register indices on the configuration port
  localparam logic       IDX_ENABLE_PIN_CFG = 1'h0;
  localparam logic       IDX_PAD_MISC_CFG   = 1'h1;
  // Enable pin register fields
  localparam int         EP_PULLDOWN_BIT    = 5;
  localparam int         EP_PULLUP_BIT      = 4;
  localparam int         EP_POLARITY_BIT    = 3;
  localparam int         EP_SELECT_BIT      = 0;
  localparam logic [7:0] EP_WRITE_MASK      = 8'h39;
  localparam logic [7:0] EP_RESET           = 8'h10;
  // Pad register fields
  localparam int         PM_STARTUP_LSB     = 6;
  localparam int         PM_PUSHPULL_LSB    = 4;
  localparam int         PM_OPENDRAIN_LSB   = 2;
  localparam int         PM_SDA_PULLUP_BIT  = 1;
  localparam int         PM_SCL_PULLUP_BIT  = 0;
  localparam logic [7:0] PM_WRITE_MASK      = 8'hFF;
  localparam logic [7:0] PM_RESET           = 8'h2F;
  // Startup gating codes
  localparam logic [1:0] STARTUP_GATE_LOCK  = 2'h0;
  localparam logic [1:0] STARTUP_NO_GATE    = 2'h2;
  // Pin and lock synchroniser depth
  localparam int         SYNC_STAGES        = 2;
endpackage : oepc_pkg

//--- shared/oepc_gate_if.sv
// Configuration and result signals between the top and the gating module
`timescale 1ns/1ps
`default_nettype none
interface oepc_gate_if #(parameter int NUM_OUT = 4);
  logic               pin_sel;
  logic               pin_pol;
  logic [1:0]         startup_mode;
  logic [NUM_OUT-1:0] drv_en;
  logic [NUM_OUT-1:0] drv_tristate;
  modport regs (output pin_sel, output pin_pol, output startup_mode,
                input drv_en, input drv_tristate);
  modport gate (input pin_sel, input pin_pol, input startup_mode,
                output drv_en, output drv_tristate);
endinterface : oepc_gate_if
`default_nettype wire

//--- rtl/oepc_gate.sv
// Output driver enable gating: pin sense, startup lock gate, power down
`timescale 1ns/1ps
`default_nettype none
module oepc_gate #(
  parameter int NUM_OUT = 4
) (
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  input  wire logic               enable_pin_i,
  input  wire logic               pll_lock_i,
  input  wire logic [NUM_OUT-1:0] driver_disable_i,
  input  wire logic [NUM_OUT-1:0] driver_power_down_i,
  oepc_gate_if.gate               gif
);
  logic [1:0] pin_sync_reg;
  logic [1:0] lock_sync_reg;
  logic       startup_open_reg;
  logic       pin_ok;
  logic       gate_open;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the asynchronous pin and lock level
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_sync_reg  <= 2'h0;
      lock_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg  <= {pin_sync_reg[0], enable_pin_i};
      lock_sync_reg <= {lock_sync_reg[0], pll_lock_i};
    end
  end

  // Startup gate opens on first lock and stays open until reset
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      startup_open_reg <= 1'b0;
    end else if (lock_sync_reg[1]) begin
      startup_open_reg <= 1'b1;
    end
  end

  // Pin sense; selection one ignores the pin entirely
  assign pin_ok = gif.pin_sel | (pin_sync_reg[1] ^ gif.pin_pol);
  // Reserved startup codes fall back to gating, the safe choice
  assign gate_open = startup_open_reg |
                     (gif.startup_mode == oepc_pkg::STARTUP_NO_GATE);

  // Registered per-driver enable and tri-state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      gif.drv_en       <= '0;
      gif.drv_tristate <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        gif.drv_en[i] <= pin_ok & gate_open & ~driver_disable_i[i] &
                         ~driver_power_down_i[i];
        gif.drv_tristate[i] <= driver_power_down_i[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_pin_disables: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!gif.pin_sel && (pin_sync_reg[1] == gif.pin_pol)) |=> !(|gif.drv_en))
    else $error("drivers on while pin deasserted");
  a_pin_ignored: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gif.pin_sel && gate_open && !driver_disable_i[0] &&
     !driver_power_down_i[0]) |=> gif.drv_en[0])
    else $error("pin level blocked driver with selection one");
  a_startup_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!startup_open_reg && gif.startup_mode != oepc_pkg::STARTUP_NO_GATE)
    |=> !(|gif.drv_en))
    else $error("drivers on before lock");
  a_lock_opens: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(lock_sync_reg[1]) |=> startup_open_reg[*3])
    else $error("startup gate did not open on lock");
  a_disable_forces: assert property (@(posedge mclk_i) disable iff (reset_i)
    driver_disable_i[0] |=> !gif.drv_en[0])
    else $error("disabled driver still on");
  a_power_down: assert property (@(posedge mclk_i) disable iff (reset_i)
    driver_power_down_i[0] |=> (gif.drv_tristate[0] && !gif.drv_en[0]))
    else $error("powered-down driver not tri-stated");
endmodule : oepc_gate
`default_nettype wire

//--- rtl/oepc_top.sv
// Top of the output-enable and pad configuration block with its registers
`timescale 1ns/1ps
`default_nettype none
module oepc_top #(
  parameter int NUM_OUT = 4
) (
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  input  wire logic               cfg_wr_i,
  input  wire logic               cfg_idx_i,
  input  wire logic [7:0]         cfg_wdata_i,
  output logic      [7:0]         cfg_rdata_o,
  input  wire logic               enable_pin_i,
  input  wire logic               pll_lock_i,
  input  wire logic [NUM_OUT-1:0] driver_disable_i,
  input  wire logic [NUM_OUT-1:0] driver_power_down_i,
  output logic      [NUM_OUT-1:0] driver_en_o,
  output logic      [NUM_OUT-1:0] driver_tristate_o,
  output logic                    enable_pin_pulldown_en_o,
  output logic                    enable_pin_pullup_en_o,
  output logic      [1:0]         push_pull_strength_o,
  output logic      [1:0]         open_drain_strength_o,
  output logic                    serial_data_pullup_en_o,
  output logic                    serial_clock_pullup_en_o
);
  // Refuse driver counts the enable vectors cannot carry
  if (NUM_OUT < 1 || NUM_OUT > 16) begin : g_num_out_check
    $error("NUM_OUT out of range");
  end

  logic [7:0] enable_pin_cfg_reg;
  logic [7:0] pad_misc_cfg_reg;
  logic [7:0] rdata_next;

  oepc_gate_if #(.NUM_OUT(NUM_OUT)) gif ();

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers; reserved bits never store
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      enable_pin_cfg_reg <= oepc_pkg::EP_RESET;
      pad_misc_cfg_reg   <= oepc_pkg::PM_RESET;
    end else if (cfg_wr_i) begin
      if (cfg_idx_i == oepc_pkg::IDX_ENABLE_PIN_CFG) begin
        enable_pin_cfg_reg <= cfg_wdata_i & oepc_pkg::EP_WRITE_MASK;
      end else begin
        pad_misc_cfg_reg <= cfg_wdata_i & oepc_pkg::PM_WRITE_MASK;
      end
    end
  end

  // Registered read data follows the selected index
  assign rdata_next = (cfg_idx_i == oepc_pkg::IDX_ENABLE_PIN_CFG) ?
                      enable_pin_cfg_reg : pad_misc_cfg_reg;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg_rdata_o <= 8'h00;
    end else begin
      cfg_rdata_o <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad controls, registered so outputs come from flops
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      // Reset levels come from the register reset words, kept in one place
      enable_pin_pulldown_en_o <=
        oepc_pkg::EP_RESET[oepc_pkg::EP_PULLDOWN_BIT];
      enable_pin_pullup_en_o <=
        oepc_pkg::EP_RESET[oepc_pkg::EP_PULLUP_BIT];
      push_pull_strength_o <=
        oepc_pkg::PM_RESET[oepc_pkg::PM_PUSHPULL_LSB +: 2];
      open_drain_strength_o <=
        oepc_pkg::PM_RESET[oepc_pkg::PM_OPENDRAIN_LSB +: 2];
      serial_data_pullup_en_o <=
        oepc_pkg::PM_RESET[oepc_pkg::PM_SDA_PULLUP_BIT];
      serial_clock_pullup_en_o <=
        oepc_pkg::PM_RESET[oepc_pkg::PM_SCL_PULLUP_BIT];
    end else begin
      enable_pin_pulldown_en_o <=
        enable_pin_cfg_reg[oepc_pkg::EP_PULLDOWN_BIT];
      enable_pin_pullup_en_o <=
        enable_pin_cfg_reg[oepc_pkg::EP_PULLUP_BIT];
      push_pull_strength_o <=
        pad_misc_cfg_reg[oepc_pkg::PM_PUSHPULL_LSB +: 2];
      open_drain_strength_o <=
        pad_misc_cfg_reg[oepc_pkg::PM_OPENDRAIN_LSB +: 2];
      serial_data_pullup_en_o <=
        pad_misc_cfg_reg[oepc_pkg::PM_SDA_PULLUP_BIT];
      serial_clock_pullup_en_o <=
        pad_misc_cfg_reg[oepc_pkg::PM_SCL_PULLUP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gating fields to the enable module
  assign gif.pin_sel      = enable_pin_cfg_reg[oepc_pkg::EP_SELECT_BIT];
  assign gif.pin_pol      = enable_pin_cfg_reg[oepc_pkg::EP_POLARITY_BIT];
  assign gif.startup_mode = pad_misc_cfg_reg[oepc_pkg::PM_STARTUP_LSB +: 2];

  oepc_gate #(.NUM_OUT(NUM_OUT)) u_gate (
    .mclk_i              (mclk_i),
    .reset_i             (reset_i),
    .enable_pin_i        (enable_pin_i),
    .pll_lock_i          (pll_lock_i),
    .driver_disable_i    (driver_disable_i),
    .driver_power_down_i (driver_power_down_i),
    .gif                 (gif.gate)
  );

  // Enables are already registered inside the gating module
  assign driver_en_o       = gif.drv_en;
  assign driver_tristate_o = gif.drv_tristate;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_pulldown_bit: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 enable_pin_pulldown_en_o ==
        $past(enable_pin_cfg_reg[oepc_pkg::EP_PULLDOWN_BIT]))
    else $error("pull-down does not follow bit 5");
  a_pullup_reset: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> (enable_pin_pullup_en_o && serial_data_pullup_en_o
                        && serial_clock_pullup_en_o))
    else $error("pull-ups not on after reset");
  a_strength_codes: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cfg_wr_i && cfg_idx_i == oepc_pkg::IDX_PAD_MISC_CFG) |=> ##1
    (push_pull_strength_o == $past(cfg_wdata_i[5:4], 2) &&
     open_drain_strength_o == $past(cfg_wdata_i[3:2], 2)))
    else $error("strength codes not applied");
  a_serial_pullups: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cfg_wr_i && cfg_idx_i == oepc_pkg::IDX_PAD_MISC_CFG) |=> ##1
    (serial_data_pullup_en_o == $past(cfg_wdata_i[1], 2) &&
     serial_clock_pullup_en_o == $past(cfg_wdata_i[0], 2)))
    else $error("serial pull-ups not applied");
  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    (enable_pin_cfg_reg & ~oepc_pkg::EP_WRITE_MASK) == 8'h00)
    else $error("reserved enable-pin bits set");
endmodule : oepc_top
`default_nettype wire

//--- bench/oepc_pin_model.sv
// Board-side model of the output-enable pin and its pull resistors
`timescale 1ns/1ps
`default_nettype none
module oepc_pin_model (
  input  wire logic mclk_i,
  input  wire logic drive_i,
  input  wire logic level_i,
  input  wire logic pullup_en_i,
  input  wire logic pulldown_en_i,
  output var  logic pin_o
);
  logic float_reg = 1'b0;
  // A released, unpulled pin wanders so it never looks settled
  always_ff @(posedge mclk_i) begin
    float_reg <= ~float_reg;
  end
  // Board driver wins; pull-up beats pull-down if both are on
  always_comb begin
    if (drive_i) begin
      pin_o = level_i;
    end else if (pullup_en_i) begin
      pin_o = 1'b1;
    end else if (pulldown_en_i) begin
      pin_o = 1'b0;
    end else begin
      pin_o = float_reg;
    end
  end
endmodule // oepc_pin_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the output-enable and pad configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] r0, r1;
    logic       pin, lock;
    logic [3:0] dis, pd, en, ts;
    logic [7:0] pads;
  } oepc_row_t;
  ////////////////////////////////////////////////////////////////////////
  logic       mclk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       cfg_wr_i = 1'b0;
  logic       cfg_idx_i = 1'b0;
  logic       pll_lock_i = 1'b0;
  logic       pin_drv = 1'b1;
  logic       pin_lvl = 1'b0;
  logic       enable_pin_i;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic [7:0] cfg_rdata_o;
  logic [3:0] driver_disable_i = 4'h0;
  logic [3:0] driver_power_down_i = 4'h0;
  logic [3:0] driver_en_o;
  logic [3:0] driver_tristate_o;
  wire  [7:0] pads;
  int         miscompares = 0;
  int         n_compared = 0;
  // Ordinary cases: registers, pin, lock, disables and expected outputs
  oepc_row_t rows [12] = '{
    '{8'h10, 8'h2F, 1'h1, 1'h0, 4'h0, 4'h0, 4'h0, 4'h0, 8'h6F},
    '{8'h10, 8'hAC, 1'h1, 1'h0, 4'h0, 4'h0, 4'hF, 4'h0, 8'h6C},
    '{8'h10, 8'hAC, 1'h0, 1'h0, 4'h0, 4'h0, 4'h0, 4'h0, 8'h6C},
    '{8'h18, 8'hAC, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 4'h0, 8'h6C},
    '{8'h18, 8'hAC, 1'h1, 1'h0, 4'h0, 4'h0, 4'h0, 4'h0, 8'h6C},
    '{8'h11, 8'hAC, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 4'h0, 8'h6C},
    '{8'hFF, 8'h1C, 1'h1, 1'h0, 4'h0, 4'h0, 4'h0, 4'h0, 8'hDC},
    '{8'hFF, 8'h1C, 1'h1, 1'h1, 4'h0, 4'h0, 4'hF, 4'h0, 8'hDC},
    '{8'h10, 8'h2F, 1'h1, 1'h1, 4'h5, 4'h0, 4'hA, 4'h0, 8'h6F},
    '{8'h10, 8'h2F, 1'h1, 1'h1, 4'h0, 4'h3, 4'hC, 4'h3, 8'h6F},
    '{8'h00, 8'h13, 1'h1, 1'h1, 4'h1, 4'h8, 4'h6, 4'h8, 8'h13},
    '{8'h10, 8'h2F, 1'h0, 1'h1, 4'h0, 4'h2, 4'h0, 4'h2, 8'h6F}};
  ////////////////////////////////////////////////////////////////////////
  // Free-running 50 MHz clock
  always #10 mclk_i = ~mclk_i;
  oepc_top #(.NUM_OUT(4)) i_dut (
    .mclk_i, .reset_i, .cfg_wr_i, .cfg_idx_i, .cfg_wdata_i, .cfg_rdata_o,
    .enable_pin_i, .pll_lock_i, .driver_disable_i, .driver_power_down_i,
    .driver_en_o, .driver_tristate_o,
    .enable_pin_pulldown_en_o (pads[7]),
    .enable_pin_pullup_en_o   (pads[6]),
    .push_pull_strength_o     (pads[5:4]),
    .open_drain_strength_o    (pads[3:2]),
    .serial_data_pullup_en_o  (pads[1]),
    .serial_clock_pullup_en_o (pads[0]));
  oepc_pin_model i_pin (
    .mclk_i        (mclk_i),
    .drive_i       (pin_drv),
    .level_i       (pin_lvl),
    .pullup_en_i   (pads[6]),
    .pulldown_en_i (pads[7]),
    .pin_o         (enable_pin_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe; next write waits an edge before raising it
  task automatic wr(input logic idx, input logic [7:0] d);
    @(posedge mclk_i);
    cfg_wr_i <= 1'b1;
    cfg_idx_i <= idx;
    cfg_wdata_i <= d;
    @(posedge mclk_i);
    cfg_wr_i <= 1'b0;
  endtask
  // Read back is sampled mid-cycle, clear of the flop updates
  task automatic rd(input logic idx, input logic [7:0] exp);
    @(posedge mclk_i);
    cfg_idx_i <= idx;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(cfg_rdata_o, exp);
  endtask
  task automatic finish_test;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, table, then hand-written cases
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(1'b0, 8'h10);
    rd(1'b1, 8'h2F);
    chk(pads, 8'h6F);
    for (int i = 0; i < 12; i++) begin
      wr(1'b0, rows[i].r0);
      wr(1'b1, rows[i].r1);
      pin_lvl <= rows[i].pin;
      pll_lock_i <= rows[i].lock;
      driver_disable_i <= rows[i].dis;
      driver_power_down_i <= rows[i].pd;
      rd(1'b0, rows[i].r0 & 8'h39);
      rd(1'b1, rows[i].r1);
      chk(pads, rows[i].pads);
      chk({driver_en_o, driver_tristate_o}, {rows[i].en, rows[i].ts});
    end
    // Board lets go of the pin; only the pull resistors decide
    wr(1'b0, 8'h10);
    pin_drv <= 1'b0;
    driver_power_down_i <= 4'h0;
    rd(1'b0, 8'h10);
    chk({4'h0, driver_en_o}, 8'h0F);
    wr(1'b0, 8'h20);
    rd(1'b0, 8'h20);
    chk({4'h0, driver_en_o}, 8'h00);
    // Second reset with lock low; pin is already settled when we look
    @(posedge mclk_i);
    reset_i <= 1'b1;
    pll_lock_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(1'b1, 8'h2F);
    chk({4'h0, driver_en_o}, 8'h00);
    // Reserved startup code gates like zero; code two never gates
    wr(1'b1, 8'hEF);
    rd(1'b1, 8'hEF);
    chk({4'h0, driver_en_o}, 8'h00);
    wr(1'b1, 8'hAF);
    rd(1'b1, 8'hAF);
    chk({4'h0, driver_en_o}, 8'h0F);
    // Back to code zero: gate shuts until lock is first seen
    wr(1'b1, 8'h2F);
    rd(1'b1, 8'h2F);
    chk({4'h0, driver_en_o}, 8'h00);
    @(posedge mclk_i);
    pll_lock_i <= 1'b1;
    rd(1'b0, 8'h10);
    chk({4'h0, driver_en_o}, 8'h0F);
    finish_test();
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge mclk_i);
    miscompares++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
